// ---- rtl/reset_timeout_sequencer.sv ----
// reset time-out sequencer with reset-cause flags and axi4-lite registers
// assumes async pin-side inputs, core events on aclk, one register bus master
//
// Summary of operation
// - power-up delay starts only after the power-on pulse ends; core held in reset
// - oscillator start-up count follows the power-up delay; core released when done
// - external clock mode with delay disabled applies no time-out at all
// - time-outs run despite reset pin; pin release then starts core at once
// - crystal modes: delay plus 1024 periods, or 1024 alone, also on wake
// - rc, external clock, internal modes: delay only if enabled, none on wake
// - power control register at index 8eh: power-on bit 1, brown-out bit 0
// - brown-out reset clears brown-out flag; software sets it afterwards
// - brown-out mode 00 disables the detector; its flag is not relied on
// - power-on reset clears power-on flag; other resets leave it alone
// - software may write power-on flag to one; it holds until power-on
// - reset cause encoded in power-on, brown-out, timeout and power-down flags
// - status loads 0001 1xxx on power-on and 000q quuu on other resets
// - wake from sleep keeps registers except cause flags; pc advances by one
// - power-up delay is a fixed 64 ms after power-on or brown-out only
// - brown-out during the delay returns to reset and restarts the delay
`default_nettype none
`include "rts_params.svh"

module reset_timeout_sequencer
  import rts_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `RTS_POWERUP_DELAY_TIMER_CYCLES,
  parameter int unsigned OST_PERIODS = `RTS_OST_PERIODS
)(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // asynchronous reset sources and oscillator
  input wire logic por_active,
  input wire logic brownout_det,
  input wire logic external_reset_pin_n,
  input wire logic osc_tick,
  // configuration and core events
  input wire cfg_s cfg,
  input wire core_ev_s core_ev,
  // sequencer outputs
  output logic core_reset,
  output logic core_stall,
  output logic pc_advance,
  output logic irq,
  // axi4-lite write
  input wire logic [`RTS_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [`RTS_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  localparam logic [`RTS_POWERUP_DELAY_TIMER_CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = `RTS_POWERUP_DELAY_TIMER_CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1);
  localparam logic [`RTS_OST_CNT_W-1:0] OST_LAST = `RTS_OST_CNT_W'(OST_PERIODS - 1);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_crystal(input osc_mode_e m);
    is_crystal = (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS);
  endfunction

  function automatic reg_sel_e decode(input logic [`RTS_ADDR_W-1:0] a);
    if (a == {`RTS_STATUS_IDX, 2'h0})
      decode = SEL_STATUS;
    else if (a == {`RTS_POWER_CONTROL_REG_IDX, 2'h0})
      decode = SEL_POWER_CONTROL_REG;
    else if (a == {`RTS_EVT_IDX, 2'h0})
      decode = SEL_EVT;
    else if (a == {`RTS_MASK_IDX, 2'h0})
      decode = SEL_MASK;
    else
      decode = SEL_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  localparam st_s ST_RESET = '{
    state: S_SRC,
    cause_pwr: 1'b1,
    // the pin idles high; starting its stages high keeps a false edge away after reset
    pin_s: 2'h3,
    pin_prev: 1'b1,
    core_reset: 1'b1,
    status: `RTS_STATUS_POR,
    power_control_reg: `RTS_POWER_CONTROL_REG_RST,
    default: '0
  };

  st_s st_q;
  st_s st_d;

  logic por_rise;
  logic bor_on;
  logic bor_rise;
  logic pin_fall;
  logic osc_rise;
  logic wdt_rst;
  logic wdt_wake;
  logic irq_wake;
  logic crystal;
  logic aw_take;
  logic w_take;
  logic [`RTS_EV_W-1:0] ev_set;
  logic [`RTS_EV_W-1:0] ev_clr;
  reg_sel_e wsel;
  reg_sel_e rsel;

  always_comb
  begin
    st_d = st_q;
    por_rise = 1'b0;
    bor_on = 1'b0;
    bor_rise = 1'b0;
    pin_fall = 1'b0;
    osc_rise = 1'b0;
    wdt_rst = 1'b0;
    wdt_wake = 1'b0;
    irq_wake = 1'b0;
    crystal = is_crystal(cfg.osc_mode);
    aw_take = 1'b0;
    w_take = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    wsel = SEL_NONE;
    rsel = SEL_NONE;
    if (clk_en)
    begin
      st_d.pc_advance = 1'b0;

      // synchronisers; edge logic reads only the second stage
      st_d.por_s = {st_q.por_s[0], por_active};
      st_d.bor_s = {st_q.bor_s[0], brownout_det};
      st_d.pin_s = {st_q.pin_s[0], external_reset_pin_n};
      st_d.osc_s = {st_q.osc_s[0], osc_tick};
      st_d.por_prev = st_q.por_s[1];
      st_d.pin_prev = st_q.pin_s[1];
      st_d.osc_prev = st_q.osc_s[1];

      // detector disabled in mode 00, so it neither resets nor flags
      bor_on = st_q.bor_s[1] && (cfg.brownout_mode_select != 2'h0);
      st_d.bor_prev = bor_on;
      por_rise = st_q.por_s[1] && !st_q.por_prev;
      bor_rise = bor_on && !st_q.bor_prev;
      pin_fall = !st_q.pin_s[1] && st_q.pin_prev;
      osc_rise = st_q.osc_s[1] && !st_q.osc_prev;
      wdt_rst = core_ev.wdt_timeout && !core_ev.sleep_active && (st_q.state == S_RUN);
      wdt_wake = core_ev.wdt_timeout && core_ev.sleep_active && (st_q.state == S_RUN);
      irq_wake = core_ev.wake_irq && core_ev.sleep_active && (st_q.state == S_RUN) && !wdt_wake;

      //////////////////////////////////////////////////////////////////////
      // time-out sequence

      if (st_q.por_s[1] || bor_on)
      begin
        // a brown-out mid-delay lands here and the delay starts over
        st_d.state = S_SRC;
        st_d.cause_pwr = 1'b1;
        st_d.wake_seq = 1'b0;
      end
      else
      begin
        case (st_q.state)
          S_SRC:
          begin
            // pin level is ignored here so time-outs overlap a held pin
            if (!st_q.cause_pwr)
              st_d.state = S_RUN;
            else if (!cfg.powerup_delay_disable)
            begin
              st_d.state = S_POWERUP_DELAY_TIMER;
              st_d.powerup_delay_timer_cnt = '0;
            end
            else if (crystal)
            begin
              st_d.state = S_OST;
              st_d.ost_cnt = '0;
            end
            else
              st_d.state = S_RUN;
          end
          S_POWERUP_DELAY_TIMER:
          begin
            if (st_q.powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_LAST)
            begin
              st_d.ost_cnt = '0;
              st_d.state = crystal ? S_OST : S_RUN;
            end
            else
              st_d.powerup_delay_timer_cnt = st_q.powerup_delay_timer_cnt + 1'b1;
          end
          S_OST:
          begin
            if (osc_rise)
            begin
              if (st_q.ost_cnt == OST_LAST)
              begin
                st_d.state = S_RUN;
                st_d.wake_seq = 1'b0;
                st_d.pc_advance = st_q.wake_seq;
                st_d.cause_pwr = 1'b0;
              end
              else
                st_d.ost_cnt = st_q.ost_cnt + 1'b1;
            end
          end
          S_RUN:
          begin
            if (wdt_rst)
            begin
              st_d.state = S_SRC;
              st_d.cause_pwr = 1'b0;
            end
            else if (wdt_wake || irq_wake)
            begin
              if (crystal)
              begin
                // wake stalls the core without resetting it
                st_d.state = S_OST;
                st_d.ost_cnt = '0;
                st_d.wake_seq = 1'b1;
              end
              else
                st_d.pc_advance = 1'b1;
            end
            else
              st_d.cause_pwr = 1'b0;
          end
          default:
            st_d.state = S_SRC;
        endcase
      end

      // a low pin only gates release; it never restarts the time-outs
      st_d.core_reset = (st_d.state == S_SRC) || (st_d.state == S_POWERUP_DELAY_TIMER) ||
                        ((st_d.state == S_OST) && !st_d.wake_seq) ||
                        !st_q.pin_s[1];

      //////////////////////////////////////////////////////////////////////
      // bus write channel

      if (st_q.bvalid && bready)
        st_d.bvalid = 1'b0;
      aw_take = awvalid && !st_q.aw_got && !st_q.bvalid;
      w_take = wvalid && !st_q.w_got && !st_q.bvalid;
      if (aw_take)
      begin
        st_d.aw_got = 1'b1;
        st_d.aw_addr = awaddr;
      end
      if (w_take)
      begin
        st_d.w_got = 1'b1;
        st_d.wdata = wdata[7:0];
        st_d.wstrb0 = wstrb[0];
      end
      if (st_d.aw_got && st_d.w_got && !st_q.bvalid)
      begin
        wsel = decode(st_d.aw_addr);
        st_d.aw_got = 1'b0;
        st_d.w_got = 1'b0;
        st_d.bvalid = 1'b1;
        st_d.bresp = (wsel == SEL_NONE) ? RESP_ERR : RESP_OK;
        if (st_d.wstrb0)
        begin
          if (wsel == SEL_STATUS)
          begin
            // timeout and power-down bits are hardware-owned
            st_d.status[7:5] = st_d.wdata[7:5];
            st_d.status[2:0] = st_d.wdata[2:0];
          end
          else if (wsel == SEL_POWER_CONTROL_REG)
            st_d.power_control_reg = st_d.wdata[1:0];
          else if (wsel == SEL_EVT)
            ev_clr = st_d.wdata[`RTS_EV_W-1:0];
          else if (wsel == SEL_MASK)
            st_d.mask = st_d.wdata[`RTS_EV_W-1:0];
        end
      end

      //////////////////////////////////////////////////////////////////////
      // reset-cause flags; hardware updates win over software writes

      if (pin_fall)
      begin
        st_d.status[7:5] = 3'h0;
        if (core_ev.sleep_active)
        begin
          st_d.status[`RTS_ST_TO] = 1'b1;
          st_d.status[`RTS_ST_PD] = 1'b0;
        end
        ev_set[`RTS_EV_PIN] = 1'b1;
      end
      if (wdt_rst)
      begin
        st_d.status[7:5] = 3'h0;
        st_d.status[`RTS_ST_TO] = 1'b0;
        ev_set[`RTS_EV_WDT] = 1'b1;
      end
      if (wdt_wake)
      begin
        st_d.status[`RTS_ST_TO] = 1'b0;
        st_d.status[`RTS_ST_PD] = 1'b0;
        ev_set[`RTS_EV_WAKE] = 1'b1;
      end
      if (irq_wake)
      begin
        st_d.status[`RTS_ST_TO] = 1'b1;
        st_d.status[`RTS_ST_PD] = 1'b0;
        ev_set[`RTS_EV_WAKE] = 1'b1;
      end
      if (bor_rise)
      begin
        st_d.status[7:5] = 3'h0;
        st_d.status[`RTS_ST_TO] = 1'b1;
        st_d.status[`RTS_ST_PD] = 1'b1;
        st_d.power_control_reg[`RTS_POWER_CONTROL_REG_BOR] = 1'b0;
        ev_set[`RTS_EV_BOR] = 1'b1;
      end
      if (por_rise)
      begin
        st_d.status = `RTS_STATUS_POR;
        st_d.power_control_reg[`RTS_POWER_CONTROL_REG_POR] = 1'b0;
        ev_set[`RTS_EV_POR] = 1'b1;
      end
      ev_set[`RTS_EV_REL] = st_q.core_reset && !st_d.core_reset;
      st_d.evt = (st_q.evt & ~ev_clr) | ev_set;

      //////////////////////////////////////////////////////////////////////
      // bus read channel

      if (st_q.rvalid && rready)
        st_d.rvalid = 1'b0;
      if (arvalid && !st_q.rvalid)
      begin
        rsel = decode(araddr);
        st_d.rvalid = 1'b1;
        st_d.rresp = (rsel == SEL_NONE) ? RESP_ERR : RESP_OK;
        st_d.rdata = 8'h00;
        if (rsel == SEL_STATUS)
          st_d.rdata = st_q.status;
        else if (rsel == SEL_POWER_CONTROL_REG)
          st_d.rdata = {6'h00, st_q.power_control_reg};
        else if (rsel == SEL_EVT)
          st_d.rdata = {2'h0, st_q.evt};
        else if (rsel == SEL_MASK)
          st_d.rdata = {2'h0, st_q.mask};
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= ST_RESET;
    else
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign core_reset = st_q.core_reset;
  assign core_stall = (st_q.state != S_RUN);
  assign pc_advance = st_q.pc_advance;
  assign irq = |(st_q.evt & st_q.mask);
  // readies drop with clk_en so nothing is accepted while frozen
  assign awready = clk_en && !st_q.aw_got && !st_q.bvalid;
  assign wready = clk_en && !st_q.w_got && !st_q.bvalid;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = clk_en && !st_q.rvalid;
  assign rvalid = st_q.rvalid;
  assign rresp = st_q.rresp;
  assign rdata = {24'h000000, st_q.rdata};

endmodule // reset_timeout_sequencer

`default_nettype wire

// ---- rtl/rts_params.svh ----
// constants of the reset time-out sequencer
// assumes a 50 MHz core clock and a 32-bit axi4-lite slave port
`ifndef RTS_PARAMS_SVH
`define RTS_PARAMS_SVH

// register indices; byte address is four times the index
`define RTS_STATUS_IDX 10'h003
`define RTS_POWER_CONTROL_REG_IDX 10'h08e
`define RTS_EVT_IDX 10'h090
`define RTS_MASK_IDX 10'h091
`define RTS_ADDR_W 12

// field positions
`define RTS_ST_TO 4
`define RTS_ST_PD 3
`define RTS_POWER_CONTROL_REG_POR 1
`define RTS_POWER_CONTROL_REG_BOR 0

// reset values
`define RTS_STATUS_POR 8'h18
`define RTS_POWER_CONTROL_REG_RST 2'h0

// event bits
`define RTS_EV_POR 0
`define RTS_EV_BOR 1
`define RTS_EV_PIN 2
`define RTS_EV_WDT 3
`define RTS_EV_WAKE 4
`define RTS_EV_REL 5
`define RTS_EV_W 6

// timing
`define RTS_CLK_MHZ 50
`define RTS_POWERUP_DELAY_TIMER_TIME_US 64000
`define RTS_POWERUP_DELAY_TIMER_CYCLES (`RTS_POWERUP_DELAY_TIMER_TIME_US * `RTS_CLK_MHZ)
`define RTS_OST_PERIODS 1024
`define RTS_POWERUP_DELAY_TIMER_CNT_W 32
`define RTS_OST_CNT_W 11

`endif

// ---- rtl/rts_pkg.sv ----
// types of the reset time-out sequencer
// assumes rts_params.svh is on the include path
`default_nettype none
`include "rts_params.svh"

package rts_pkg;

  typedef enum logic [2:0] {
    OSC_LP = 3'h0, OSC_XT = 3'h1, OSC_HS = 3'h2, OSC_EC = 3'h3,
    OSC_INTIO = 3'h4, OSC_INT = 3'h5, OSC_RCIO = 3'h6, OSC_RC = 3'h7
  } osc_mode_e;

  typedef enum logic [3:0] {
    S_RUN = 4'h1, S_SRC = 4'h2, S_POWERUP_DELAY_TIMER = 4'h4, S_OST = 4'h8
  } seq_state_e;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_STATUS, SEL_POWER_CONTROL_REG, SEL_EVT, SEL_MASK
  } reg_sel_e;

  typedef struct packed {
    osc_mode_e osc_mode;
    logic powerup_delay_disable;
    logic [1:0] brownout_mode_select;
  } cfg_s;

  typedef struct packed {
    logic wdt_timeout;
    logic wake_irq;
    logic sleep_active;
  } core_ev_s;

  typedef struct packed {
    logic [1:0] por_s;
    logic [1:0] bor_s;
    logic [1:0] pin_s;
    logic [1:0] osc_s;
    logic por_prev;
    logic bor_prev;
    logic pin_prev;
    logic osc_prev;
    seq_state_e state;
    logic cause_pwr;
    logic wake_seq;
    logic [`RTS_POWERUP_DELAY_TIMER_CNT_W-1:0] powerup_delay_timer_cnt;
    logic [`RTS_OST_CNT_W-1:0] ost_cnt;
    logic core_reset;
    logic pc_advance;
    logic [7:0] status;
    logic [1:0] power_control_reg;
    logic [`RTS_EV_W-1:0] evt;
    logic [`RTS_EV_W-1:0] mask;
    logic aw_got;
    logic [`RTS_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } st_s;

endpackage

`default_nettype wire

// ---- testbench/reset_timeout_sequencer_tb.sv ----
// self-checking bench for the reset time-out sequencer
// assumes rts_pkg compiled first; short delay and start-up counts
`default_nettype none

module reset_timeout_sequencer_tb
  import rts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {osc_mode_e m; logic d; int lo;} row_s;
  localparam logic [11:0] A_ST = 12'h00c, A_PC = 12'h238, A_EV = 12'h240, A_MK = 12'h244;
  logic aclk = 1'b0;
  logic aresetn, clk_en, por_active, brownout_det, external_reset_pin_n;
  logic osc_tick = 1'b0;
  logic [1:0] oc = 2'h0;
  cfg_s cfg;
  core_ev_s core_ev;
  logic core_reset, core_stall, pc_advance, irq;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [7:0] d;
  int errors = 0, check_count = 0, n;
  // delay 20 cycles, 8 ticks of 4 cycles each
  row_s rows[9] = '{'{OSC_LP, 1'b0, 48}, '{OSC_XT, 1'b1, 28}, '{OSC_HS, 1'b0, 48},
    '{OSC_EC, 1'b1, 0}, '{OSC_EC, 1'b0, 20}, '{OSC_INTIO, 1'b1, 0}, '{OSC_INT, 1'b0, 20},
    '{OSC_RCIO, 1'b1, 0}, '{OSC_RC, 1'b0, 20}};

  reset_timeout_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(20), .OST_PERIODS(8)) dut_u (.*);

  always #10 aclk = ~aclk;
  always @(posedge aclk)
  begin
    oc <= oc + 2'h1;
    osc_tick <= oc[1];
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic rng(input string s, input int lo, input int hi);
    check_count++;
    if (n < lo || n > hi)
    begin
      errors++;
      $display("unexpected %s exp %0d..%0d got %0d", s, lo, hi, n);
    end
  endtask

  // counts cycles until core release (pc=0) or a wake pulse (pc=1)
  task automatic wt(input bit pc);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end while ((pc ? pc_advance !== 1'b1 : core_reset !== 1'b0) && n < 500);
    @(posedge aclk);
  endtask

  // both halves offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic aw, w, b;
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do
    begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      k++;
    end while (!b && k < 50);
    bready <= 1'b0;
    chk("write answered", 1'b1, b);
  endtask

  task automatic rd(input logic [11:0] a);
    logic ar, v;
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do
    begin
      @(negedge aclk);
      ar = arvalid && arready;
      v = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      k++;
    end while (!v && k < 50);
    rready <= 1'b0;
    chk("read answered", 1'b1, v);
  endtask

  task automatic pulse_por;
    @(posedge aclk);
    por_active <= 1'b1;
    repeat (6) @(posedge aclk);
    por_active <= 1'b0;
  endtask

  task automatic pin_rst;
    @(posedge aclk);
    external_reset_pin_n <= 1'b0;
    repeat (5) @(posedge aclk);
    external_reset_pin_n <= 1'b1;
    wt(0);
    rng("pin reset release", 0, 6);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    errors++;
    stop_test();
  end

  initial
  begin
    aresetn = 1'b0; clk_en = 1'b1; por_active = 1'b1; brownout_det = 1'b0;
    external_reset_pin_n = 1'b1; cfg = '{OSC_XT, 1'b0, 2'b01}; core_ev = '0;
    awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = 4'hf; wvalid = 1'b0; bready = 1'b0;
    araddr = '0; arvalid = 1'b0; rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_ST); chk("status rst", 8'h18, d);
    rd(12'h100); chk("unmapped resp", 2'b10, r);
    wr(A_PC, 8'hff); rd(A_PC); chk("power_control_reg bits", 8'h03, d);
    por_active <= 1'b0;
    wt(0);
    rng("first release", 48, 60);
    $display("test reset done");
    foreach (rows[i])
    begin
      cfg <= '{rows[i].m, rows[i].d, 2'b01};
      wr(A_PC, 8'h03);
      pulse_por();
      wt(0); rng("release", rows[i].lo, rows[i].lo + 12);
      rd(A_PC); chk("power_control_reg por", 1'b0, d[1]);
      rd(A_ST); chk("status por", 8'h18, d & 8'hf8);
    end
    $display("test timeouts done");
    cfg <= '{OSC_XT, 1'b0, 2'b01};
    external_reset_pin_n <= 1'b0;
    pulse_por();
    repeat (150) @(posedge aclk);
    @(negedge aclk);
    chk("held by pin", 1'b1, core_reset);
    @(posedge aclk);
    external_reset_pin_n <= 1'b1;
    wt(0); rng("pin release", 0, 6);
    $display("test pin done");
    wr(A_ST, 8'he5); rd(A_ST); chk("status ro", 8'hfd, d);
    wr(A_PC, 8'h03);
    pin_rst();
    rd(A_ST); chk("status pin", 8'h1d, d);
    rd(A_PC); chk("power_control_reg pin", 8'h03, d);
    core_ev.wdt_timeout <= 1'b1;
    @(posedge aclk);
    core_ev.wdt_timeout <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(A_ST); chk("status wdt", 8'h0d, d);
    cfg <= '{OSC_EC, 1'b0, 2'b01};
    brownout_det <= 1'b1;
    repeat (4) @(posedge aclk);
    brownout_det <= 1'b0;
    repeat (10) @(posedge aclk);
    brownout_det <= 1'b1;
    repeat (4) @(posedge aclk);
    brownout_det <= 1'b0;
    wt(0); rng("bor restart", 20, 32);
    rd(A_ST); chk("status bor", 8'h1d, d);
    rd(A_PC); chk("power_control_reg bor", 8'h02, d);
    cfg <= '{OSC_EC, 1'b0, 2'b00};
    brownout_det <= 1'b1;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("bor off", 1'b0, core_reset);
    @(posedge aclk);
    brownout_det <= 1'b0;
    $display("test causes done");
    core_ev <= '{1'b0, 1'b1, 1'b1};
    @(posedge aclk);
    core_ev.wake_irq <= 1'b0;
    wt(1); rng("irq wake", 0, 6);
    rd(A_ST); chk("status wake", 8'h15, d);
    cfg <= '{OSC_XT, 1'b0, 2'b01};
    core_ev.wdt_timeout <= 1'b1;
    @(posedge aclk);
    core_ev.wdt_timeout <= 1'b0;
    wt(1); rng("wdt wake", 28, 44);
    chk("no reset", 1'b0, core_reset);
    core_ev.sleep_active <= 1'b0;
    rd(A_ST); chk("status wwake", 8'h05, d);
    $display("test wake done");
    clk_en <= 1'b0;
    repeat (3) @(posedge aclk);
    clk_en <= 1'b1;
    wr(A_EV, 8'h3f); rd(A_EV); chk("evt clear", 8'h00, d);
    wr(A_MK, 8'h20);
    wr(12'h100, 8'hff);
    chk("unmapped wresp", 2'b10, r);
    wstrb <= 4'h0;
    wr(A_MK, 8'h3f);
    chk("strobe resp", 2'b00, r);
    wstrb <= 4'hf;
    rd(A_MK);
    chk("mask kept", 8'h20, d);
    @(negedge aclk); chk("irq idle", 1'b0, irq);
    pin_rst();
    @(negedge aclk); chk("irq set", 1'b1, irq);
    rd(A_EV); chk("evt pin", 8'h24, d);
    wr(A_EV, 8'h3f);
    @(negedge aclk); chk("irq clr", 1'b0, irq);
    $display("test irq done");
    stop_test();
  end
endmodule // reset_timeout_sequencer_tb

bind reset_timeout_sequencer rts_checker #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES), .OST_PERIODS(OST_PERIODS)) chk_u (.*);

`default_nettype wire

// ---- testbench/rts_checker.sv ----
// port assertions for the reset time-out sequencer
// assumes it is bound to reset_timeout_sequencer, one clock aclk
`default_nettype none

module rts_checker
  import rts_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 20,
  parameter int unsigned OST_PERIODS = 8
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // sources and configuration
  input wire logic por_active,
  input wire logic brownout_det,
  input wire logic external_reset_pin_n,
  input wire logic osc_tick,
  input wire cfg_s cfg,
  input wire core_ev_s core_ev,
  // sequencer outputs
  input wire logic core_reset,
  input wire logic core_stall,
  input wire logic pc_advance,
  input wire logic irq,
  // register bus
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  //////////////////////////////////////////////////////////////////////////////
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_ranswer;
    arvalid && arready |=> rvalid;
  endproperty
  a_ranswer: assert property (p_ranswer) else $error("read not answered");
  property p_frz;
    !clk_en |-> !awready && !wready && !arready;
  endproperty
  a_frz: assert property (p_frz) else $error("bus ready while frozen");
  // synchroniser latency is covered by the four cycle run-in
  property p_por;
    (por_active && clk_en) [*4] |-> core_reset;
  endproperty
  a_por: assert property (p_por) else $error("core runs during power-on pulse");
  property p_pin;
    (!external_reset_pin_n && clk_en) [*4] |-> core_reset;
  endproperty
  a_pin: assert property (p_pin) else $error("core runs with reset pin low");
  // a low pin resets the core while the sequencer itself sits in run
  property p_stall;
    $fell(core_reset) |-> !core_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("core released while sequencing");
  property p_pc;
    pc_advance |-> !core_reset ##1 !pc_advance;
  endproperty
  a_pc: assert property (p_pc) else $error("bad wake advance pulse");
  property p_wdt;
    core_ev.wdt_timeout && !core_ev.sleep_active && !core_stall && clk_en |-> ##[1:3] core_reset;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset not applied");

  c_rel: cover property ($fell(core_reset));
  c_wake: cover property (pc_advance);
  c_err: cover property (bvalid && bresp == 2'b10);
endmodule // rts_checker

`default_nettype wire
